//--- core/sbo_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef SBO_REGS_SVH
`define SBO_REGS_SVH

`define SBO_ADDR_W 5
`define SBO_OFS_BOOT_DEBUG_LOCK 5'h00
`define SBO_OFS_LOADER_PART 5'h04
`define SBO_OFS_BROWNOUT 5'h08
`define SBO_OFS_WATCHDOG 5'h0c
`define SBO_OFS_CHIP_CONTROL 5'h10
`define SBO_OFS_TIMED_ACCESS 5'h14
`define SBO_OFS_AUX_RESET_FLAGS 5'h18
`define SBO_OFS_STATUS 5'h1c

`define SBO_OPT_ERASED 8'hff
`define SBO_BYTE_ZERO 8'h00
`define SBO_WORD_ZERO 32'h0000_0000

// boot_debug_lock_options fields
`define SBO_BIT_BOOT_SEL 7
`define SBO_BIT_DBG_PWM 5
`define SBO_BIT_DBG_EN_N 4
`define SBO_BIT_RST_PIN 2
`define SBO_BIT_LOCK 1
// loader_partition_options field
`define SBO_LDR_HI 2
`define SBO_LDR_LO 0
`define SBO_LDR_NONE 3'h7
`define SBO_LDR_1K 3'h6
`define SBO_LDR_2K 3'h5
`define SBO_LDR_3K 3'h4
`define SBO_LDR_KB_0 3'h0
`define SBO_LDR_KB_1 3'h1
`define SBO_LDR_KB_2 3'h2
`define SBO_LDR_KB_3 3'h3
`define SBO_LDR_KB_4 3'h4
`define SBO_FLASH_KB 6'h20
// brownout_options fields
`define SBO_BIT_BOD_ON 7
`define SBO_BOV_HI 5
`define SBO_BOV_LO 4
`define SBO_BIT_BOD_IAP 3
`define SBO_BIT_BOD_RST 2
// watchdog_options field
`define SBO_WDT_HI 7
`define SBO_WDT_LO 4
`define SBO_WDT_OFF 4'hf
`define SBO_WDT_STOP_IDLE 4'h5
// chip_control_reg fields
`define SBO_BIT_SOFT_RST 7
`define SBO_BIT_CHIP_ERASE 0
// aux_reset_flags_reg fields
`define SBO_BIT_SOFT_FLAG 7
`define SBO_BIT_PIN_FLAG 6
`define SBO_BIT_FAULT_FLAG 5
// timed_access unlock keys
`define SBO_TA_KEY1 8'haa
`define SBO_TA_KEY2 8'h55
`define SBO_TA_WINDOW_CYC 3'h4

// Internal reset pulse
`define SBO_CLK_NS 50
`define SBO_RST_HOLD_NS 400
`define SBO_RST_HOLD_CYC ((`SBO_RST_HOLD_NS + `SBO_CLK_NS - 1) / `SBO_CLK_NS)
`define SBO_RST_CNT_W 4

`define SBO_PWM_N 6

`endif

//--- core/sbo_pkg.sv
// Types shared by the soft reset and boot option block
package sbo_pkg;
    `include "sbo_regs.svh"

    typedef enum logic [0:0] {
        SBO_RUN,
        SBO_HOLD
    } sbo_rst_state_t;

    typedef enum logic [2:0] {
        SBO_SRC_POR,
        SBO_SRC_SOFT,
        SBO_SRC_PIN,
        SBO_SRC_FAULT,
        SBO_SRC_BOD,
        SBO_SRC_WDT
    } sbo_src_t;

    // Decoded option latches
    typedef struct packed {
        logic boot_sel;
        logic dbg_pwm_tri;
        logic dbg_en_n;
        logic rst_pin_fn;
        logic lock_n;
        logic [2:0] loader_size;
        logic bod_on;
        logic [1:0] bod_level;
        logic bod_iap;
        logic bod_rst;
        logic [3:0] wdt_mode;
    } sbo_latch_t;

    // Outputs toward the rest of the chip
    typedef struct packed {
        logic sys_reset;
        logic core_halt;
        logic boot_from_loader;
        logic [2:0] loader_kbytes;
        logic [5:0] app_kbytes;
        logic debug_enable;
        logic [`SBO_PWM_N-1:0] pwm_oe;
        logic reset_pin_active;
        logic gpio_p20_in;
        logic bod_enable;
        logic [1:0] bod_level;
        logic iap_allow;
        logic wdt_reset_en;
        logic wdt_run_in_idle;
        logic [7:0] prog_read_data;
        logic prog_write_ok;
        logic flash_erase_all;
    } sbo_out_t;

    typedef struct packed {
        sbo_rst_state_t rst_state;
        sbo_src_t src;
        logic [`SBO_RST_CNT_W-1:0] rst_cnt;
        logic [7:0] opt0;
        logic [7:0] opt1;
        logic [7:0] opt2;
        logic [7:0] opt4;
        sbo_latch_t lat;
        logic soft_flag;
        logic pin_flag;
        logic fault_flag;
        logic ta_key1_seen;
        logic [2:0] ta_window;
        logic waitrequest;
        logic [31:0] readdata;
        sbo_out_t out;
    } sbo_state_t;
endpackage

//--- core/sbo_ctrl.sv
// Soft reset, reset flags and option byte decoding with an Avalon-MM slave
//
// Design decisions made here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`include "sbo_regs.svh"

module sbo_ctrl
    import sbo_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    // Avalon-MM slave
    input wire logic [`SBO_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Reset sources and chip status
    input wire logic reset_pin_in,
    input wire logic hard_fault_req,
    input wire logic wdt_reset_req,
    input wire logic supply_below_bod,
    input wire logic debug_mode,
    input wire logic debug_halt,
    input wire logic [`SBO_PWM_N-1:0] pwm_enable,
    // External programmer path
    input wire logic [7:0] prog_flash_data,
    input wire logic prog_sel_option,
    // Outputs to the chip
    output sbo_out_t chip_out
);
    sbo_state_t st;
    sbo_state_t next_st;

    logic req;
    logic wr_now;
    logic ta_open;
    logic [7:0] wbyte;
    logic [31:0] rd_mux;
    logic opt_locked;
    logic pin_reset;
    logic fault_reset;
    logic bod_reset;
    logic soft_req;
    logic erase_req;
    logic start_reset;
    sbo_src_t new_src;
    logic pwm_tri_now;

    assign avs_readdata = st.readdata;
    assign avs_waitrequest = st.waitrequest;
    assign chip_out = st.out;

    // Registered option latches give a stable view; the stored bytes may differ until reset, the brown-out byte until power-on reset
    always_comb begin
        rd_mux = `SBO_WORD_ZERO;
        case (avs_address)
            `SBO_OFS_BOOT_DEBUG_LOCK: rd_mux[7:0] = st.opt0;
            `SBO_OFS_LOADER_PART: rd_mux[7:0] = st.opt1;
            `SBO_OFS_BROWNOUT: rd_mux[7:0] = st.opt2;
            `SBO_OFS_WATCHDOG: rd_mux[7:0] = st.opt4;
            `SBO_OFS_TIMED_ACCESS: rd_mux[2:0] = st.ta_window;
            `SBO_OFS_AUX_RESET_FLAGS: begin
                rd_mux[`SBO_BIT_SOFT_FLAG] = st.soft_flag;
                rd_mux[`SBO_BIT_PIN_FLAG] = st.pin_flag;
                rd_mux[`SBO_BIT_FAULT_FLAG] = st.fault_flag;
            end
            // Trigger and erase bits are write-only
            `SBO_OFS_CHIP_CONTROL: rd_mux = `SBO_WORD_ZERO;
            `SBO_OFS_STATUS: rd_mux[$bits(sbo_latch_t)-1:0] = st.lat;
            default: rd_mux = `SBO_WORD_ZERO;
        endcase
    end

    always_comb begin
        next_st = st;
        req = avs_read | avs_write;
        // Write takes effect only on the edge where waitrequest is seen low
        wr_now = avs_write & ~st.waitrequest;
        wbyte = avs_byteenable[0] ? avs_writedata[7:0] : `SBO_BYTE_ZERO;
        ta_open = st.ta_window != 3'h0;
        opt_locked = ~st.opt0[`SBO_BIT_LOCK];
        erase_req = 1'b0;
        soft_req = 1'b0;
        next_st.out.flash_erase_all = 1'b0;

        // Bus handshake: one wait cycle, then one answer cycle
        if (req && st.waitrequest) begin
            next_st.waitrequest = 1'b0;
            next_st.readdata = avs_read ? rd_mux : `SBO_WORD_ZERO;
        end else begin
            next_st.waitrequest = 1'b1;
        end

        if (ta_open) begin
            next_st.ta_window = st.ta_window - 3'h1;
        end

        if (wr_now && avs_byteenable[0]) begin
            case (avs_address)
                `SBO_OFS_BOOT_DEBUG_LOCK: begin
                    if (!opt_locked) begin
                        next_st.opt0 = wbyte;
                    end
                end
                `SBO_OFS_LOADER_PART: begin
                    if (!opt_locked) begin
                        next_st.opt1 = wbyte;
                    end
                end
                `SBO_OFS_BROWNOUT: begin
                    if (!opt_locked) begin
                        next_st.opt2 = wbyte;
                    end
                end
                `SBO_OFS_WATCHDOG: begin
                    if (!opt_locked) begin
                        next_st.opt4 = wbyte;
                    end
                end
                `SBO_OFS_TIMED_ACCESS: begin
                    next_st.ta_key1_seen = wbyte == `SBO_TA_KEY1;
                    if (st.ta_key1_seen && wbyte == `SBO_TA_KEY2) begin
                        next_st.ta_window = `SBO_TA_WINDOW_CYC;
                    end
                end
                `SBO_OFS_CHIP_CONTROL: begin
                    // A protected write spends the unlock whether or not it sets a bit
                    next_st.ta_window = 3'h0;
                    if (ta_open) begin
                        soft_req = wbyte[`SBO_BIT_SOFT_RST];
                        erase_req = wbyte[`SBO_BIT_CHIP_ERASE];
                    end
                end
                `SBO_OFS_AUX_RESET_FLAGS: begin
                    // Clears here lose against any hardware set below
                    next_st.soft_flag = wbyte[`SBO_BIT_SOFT_FLAG];
                    next_st.pin_flag = wbyte[`SBO_BIT_PIN_FLAG];
                    next_st.fault_flag = wbyte[`SBO_BIT_FAULT_FLAG];
                end
                default: begin
                end
            endcase
        end

        // Whole-chip erase and reset_n, which loads erased option bytes, are the only paths that can unlock a locked part
        if (erase_req) begin
            next_st.opt0 = `SBO_OPT_ERASED;
            next_st.opt1 = `SBO_OPT_ERASED;
            next_st.opt2 = `SBO_OPT_ERASED;
            next_st.opt4 = `SBO_OPT_ERASED;
            next_st.out.flash_erase_all = 1'b1;
        end

        // Reset sources
        pin_reset = 1'b0;
        if (st.lat.rst_pin_fn && !reset_pin_in) begin
            pin_reset = 1'b1;
        end

        // Debugger with debug on sees the fault flag, core keeps running
        fault_reset = 1'b0;
        if (hard_fault_req && !(debug_mode && !st.lat.dbg_en_n)) begin
            fault_reset = 1'b1;
        end

        bod_reset = 1'b0;
        if (st.lat.bod_on && st.lat.bod_rst && supply_below_bod) begin
            bod_reset = 1'b1;
        end
        if (hard_fault_req) begin
            next_st.fault_flag = 1'b1;
        end

        start_reset = 1'b0;
        new_src = st.src;
        if (soft_req) begin
            start_reset = 1'b1;
            new_src = SBO_SRC_SOFT;
        end else if (pin_reset) begin
            start_reset = 1'b1;
            new_src = SBO_SRC_PIN;
        end else if (bod_reset) begin
            start_reset = 1'b1;
            new_src = SBO_SRC_BOD;
        end else if (wdt_reset_req && st.lat.wdt_mode != `SBO_WDT_OFF) begin
            start_reset = 1'b1;
            new_src = SBO_SRC_WDT;
        end else if (fault_reset) begin
            start_reset = 1'b1;
            new_src = SBO_SRC_FAULT;
        end

        if (soft_req) begin
            // Core stops on the edge that accepts the trigger write
            next_st.out.core_halt = 1'b1;
        end

        case (st.rst_state)
            SBO_RUN: begin
                if (start_reset) begin
                    next_st.rst_state = SBO_HOLD;
                    next_st.src = new_src;
                    next_st.rst_cnt = `SBO_RST_CNT_W'(`SBO_RST_HOLD_CYC);
                    next_st.out.sys_reset = 1'b1;
                    next_st.out.core_halt = 1'b1;
                    if (new_src == SBO_SRC_SOFT) begin
                        next_st.soft_flag = 1'b1;
                        next_st.fault_flag = 1'b0;
                    end
                    if (new_src == SBO_SRC_PIN) begin
                        next_st.pin_flag = 1'b1;
                        next_st.fault_flag = 1'b0;
                    end
                end
            end
            SBO_HOLD: begin
                // A held reset pin keeps the chip in reset
                if (pin_reset) begin
                    next_st.rst_cnt = `SBO_RST_CNT_W'(`SBO_RST_HOLD_CYC);
                end else if (st.rst_cnt != `SBO_RST_CNT_W'(0)) begin
                    next_st.rst_cnt = st.rst_cnt - `SBO_RST_CNT_W'(1);
                end else begin
                    next_st.rst_state = SBO_RUN;
                    next_st.out.sys_reset = 1'b0;
                    next_st.out.core_halt = 1'b0;
                    // Reload boot, debug, pin and lock latches on every reset
                    next_st.lat.dbg_pwm_tri = st.opt0[`SBO_BIT_DBG_PWM];
                    next_st.lat.dbg_en_n = st.opt0[`SBO_BIT_DBG_EN_N];
                    next_st.lat.rst_pin_fn = st.opt0[`SBO_BIT_RST_PIN];
                    next_st.lat.lock_n = st.opt0[`SBO_BIT_LOCK];
                    next_st.lat.loader_size = st.opt1[`SBO_LDR_HI:`SBO_LDR_LO];
                    next_st.lat.wdt_mode = st.opt4[`SBO_WDT_HI:`SBO_WDT_LO];
                    next_st.lat.boot_sel = st.opt0[`SBO_BIT_BOOT_SEL];
                    if (st.src == SBO_SRC_POR) begin
                        next_st.lat.bod_on = st.opt2[`SBO_BIT_BOD_ON];
                        next_st.lat.bod_level = st.opt2[`SBO_BOV_HI:`SBO_BOV_LO];
                        next_st.lat.bod_iap = st.opt2[`SBO_BIT_BOD_IAP];
                        next_st.lat.bod_rst = st.opt2[`SBO_BIT_BOD_RST];
                    end
                    // Soft reset keeps the previous boot block
                    if (st.src != SBO_SRC_SOFT) begin
                        next_st.out.boot_from_loader = ~st.opt0[`SBO_BIT_BOOT_SEL];
                    end
                end
            end
            default: begin
                next_st.rst_state = SBO_HOLD;
            end
        endcase

        // Decoded outputs, all registered
        next_st.out.debug_enable = ~st.lat.dbg_en_n;

        // Halt tri-state touches only channels that drive pins
        pwm_tri_now = debug_halt & st.lat.dbg_pwm_tri;
        for (int i = 0; i < `SBO_PWM_N; i++) begin
            next_st.out.pwm_oe[i] = pwm_enable[i] & ~pwm_tri_now;
        end

        // Shared pin: reset input or plain input, never both
        next_st.out.reset_pin_active = st.lat.rst_pin_fn;
        if (st.lat.rst_pin_fn) begin
            next_st.out.gpio_p20_in = 1'b1;
        end else begin
            next_st.out.gpio_p20_in = reset_pin_in;
        end

        case (st.lat.loader_size)
            `SBO_LDR_NONE: next_st.out.loader_kbytes = `SBO_LDR_KB_0;
            `SBO_LDR_1K: next_st.out.loader_kbytes = `SBO_LDR_KB_1;
            `SBO_LDR_2K: next_st.out.loader_kbytes = `SBO_LDR_KB_2;
            `SBO_LDR_3K: next_st.out.loader_kbytes = `SBO_LDR_KB_3;
            default: next_st.out.loader_kbytes = `SBO_LDR_KB_4;
        endcase
        next_st.out.app_kbytes = `SBO_FLASH_KB - {3'h0, next_st.out.loader_kbytes};

        next_st.out.bod_enable = st.lat.bod_on;
        next_st.out.bod_level = st.lat.bod_level;
        if (st.lat.bod_on && st.lat.bod_iap && supply_below_bod) begin
            next_st.out.iap_allow = 1'b0;
        end else begin
            next_st.out.iap_allow = 1'b1;
        end

        case (st.lat.wdt_mode)
            `SBO_WDT_OFF: begin
                next_st.out.wdt_reset_en = 1'b0;
                next_st.out.wdt_run_in_idle = 1'b0;
            end
            `SBO_WDT_STOP_IDLE: begin
                next_st.out.wdt_reset_en = 1'b1;
                next_st.out.wdt_run_in_idle = 1'b0;
            end
            default: begin
                next_st.out.wdt_reset_en = 1'b1;
                next_st.out.wdt_run_in_idle = 1'b1;
            end
        endcase

        // Option bytes stay readable to the programmer even when locked
        if (prog_sel_option) begin
            next_st.out.prog_read_data = prog_flash_data;
        end else begin
            next_st.out.prog_read_data = st.lat.lock_n ? prog_flash_data : `SBO_OPT_ERASED;
        end
        next_st.out.prog_write_ok = st.lat.lock_n;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st.rst_state <= SBO_HOLD;
            st.src <= SBO_SRC_POR;
            st.rst_cnt <= `SBO_RST_CNT_W'(`SBO_RST_HOLD_CYC);
            st.opt0 <= `SBO_OPT_ERASED;
            st.opt1 <= `SBO_OPT_ERASED;
            st.opt2 <= `SBO_OPT_ERASED;
            st.opt4 <= `SBO_OPT_ERASED;
            st.lat <= '1;

            st.soft_flag <= 1'b0;
            st.pin_flag <= 1'b0;
            st.fault_flag <= 1'b0;
            st.ta_key1_seen <= 1'b0;
            st.ta_window <= 3'h0;
            st.waitrequest <= 1'b1;
            st.readdata <= `SBO_WORD_ZERO;

            // System held and core stopped until the stretch ends
            st.out.sys_reset <= 1'b1;
            st.out.core_halt <= 1'b1;
            st.out.boot_from_loader <= 1'b0;
            st.out.loader_kbytes <= '0;
            st.out.app_kbytes <= '0;
            st.out.debug_enable <= 1'b0;
            st.out.pwm_oe <= '0;
            st.out.reset_pin_active <= 1'b0;
            st.out.gpio_p20_in <= 1'b0;
            st.out.bod_enable <= 1'b0;
            st.out.bod_level <= '0;
            st.out.iap_allow <= 1'b1;
            st.out.wdt_reset_en <= 1'b0;
            st.out.wdt_run_in_idle <= 1'b0;
            st.out.prog_read_data <= `SBO_OPT_ERASED;
            st.out.prog_write_ok <= 1'b0;
            st.out.flash_erase_all <= 1'b0;
        end else if (clk_en) begin
            st <= next_st;
        end
    end
endmodule

//--- verification/sbo_ctrl_props.sv
// Port-level concurrent checks for the soft reset and boot option block
`timescale 1ns/1ps
`include "sbo_regs.svh"
module sbo_ctrl_props
    import sbo_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic hard_fault_req,
    input wire logic debug_mode,
    input wire logic [`SBO_PWM_N-1:0] pwm_enable,
    input sbo_out_t chip_out
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    chk_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest && clk_en
        |=> !avs_waitrequest) else $error("bus request not answered after one wait cycle");
    chk_answer_single: assert property (!avs_waitrequest && clk_en |=> avs_waitrequest)
        else $error("bus answer held longer than one cycle");
    chk_no_spurious: assert property (!(avs_read || avs_write) && avs_waitrequest
        |=> avs_waitrequest) else $error("bus answer without a request");
    chk_rdata_upper: assert property (!avs_waitrequest |-> avs_readdata[31:20] == 12'h000)
        else $error("read data upper bits not zero");
    // Soft and pin resets both hold the system for the full stretch
    chk_hold_len: assert property ($rose(chip_out.sys_reset) |-> chip_out.sys_reset[*8])
        else $error("system reset shorter than the hold time");
    chk_halt_reset: assert property ($rose(chip_out.core_halt) |-> chip_out.sys_reset)
        else $error("core halted without system reset");
    chk_erase_pulse: assert property (chip_out.flash_erase_all |=> !chip_out.flash_erase_all)
        else $error("whole-chip erase not a single pulse");
    chk_pwm_subset: assert property (clk_en
        |=> (chip_out.pwm_oe & ~$past(pwm_enable)) == 6'h00)
        else $error("pwm output enabled on a channel without pwm enable");
    chk_gpio_idle: assert property (chip_out.reset_pin_active |-> chip_out.gpio_p20_in)
        else $error("shared pin reads as port while it is the reset input");
    chk_ldr_sum: assert property (!chip_out.sys_reset && !$past(chip_out.sys_reset, 2)
        |-> {3'h0, chip_out.loader_kbytes} + chip_out.app_kbytes == 6'h20)
        else $error("loader and application sizes do not fill the flash");
    chk_fault_masked: assert property (chip_out.debug_enable && debug_mode && hard_fault_req
        && !chip_out.sys_reset |=> !chip_out.sys_reset ##1 !chip_out.sys_reset)
        else $error("hard fault reset while debugging");
endmodule

bind sbo_ctrl sbo_ctrl_props chk_u (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .hard_fault_req(hard_fault_req),
    .debug_mode(debug_mode),
    .pwm_enable(pwm_enable),
    .chip_out(chip_out)
);

//--- verification/tb_top.sv
// Self-checking bench for the soft reset and boot option block
`timescale 1ns/1ps
`include "sbo_regs.svh"
module tb_top
    import sbo_pkg::*;
;
    logic clk_sys, reset_n, clk_en, avs_read, avs_write, avs_waitrequest;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, d;
    logic [3:0] avs_byteenable;
    logic pin, fault, wdt_req, low_vdd, debug_mode, debug_halt, prog_sel;
    logic [5:0] pwm_enable;
    logic [7:0] prog_data;
    sbo_out_t co;
    int checked, miscompares, i;
    logic [7:0] ldr_v [6] = '{8'h07, 8'h06, 8'h05, 8'h04, 8'h03, 8'h00};
    logic [7:0] wdt_v [6] = '{8'hf0, 8'h50, 8'h30, 8'hf0, 8'h00, 8'h50};
    logic [2:0] kb_v [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h4};

    sbo_ctrl dut_u (
        .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .reset_pin_in(pin), .hard_fault_req(fault), .wdt_reset_req(wdt_req),
        .supply_below_bod(low_vdd), .debug_mode(debug_mode), .debug_halt(debug_halt),
        .pwm_enable(pwm_enable), .prog_flash_data(prog_data), .prog_sel_option(prog_sel),
        .chip_out(co)
    );

    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One request per call; the idle edge first keeps strobes from toggling twice
    task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] wd);
        int n;
        @(posedge clk_sys);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= wd;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        d = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 100) begin
            miscompares++;
            $display("CHECK FAILED bus answer expected 0 seen %b", avs_waitrequest);
            print_verdict();
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        xfer(1'b1, a, {24'h0, v});
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
        xfer(1'b0, a, 32'h0);
        chk("register read", {24'h0, e}, d);
    endtask

    task automatic wait_run;
        int n;
        n = 0;
        while (co.sys_reset !== 1'b0 && n < 300) begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 300) begin
            miscompares++;
            $display("CHECK FAILED reset release expected 0 seen %b", co.sys_reset);
            print_verdict();
        end
        repeat (3) @(posedge clk_sys);
    endtask

    task automatic pin_rst;
        @(posedge clk_sys);
        pin <= 1'b0;
        repeat (6) @(posedge clk_sys);
        pin <= 1'b1;
        @(posedge clk_sys);
        wait_run();
    endtask

    task automatic unlock;
        wr(`SBO_OFS_TIMED_ACCESS, `SBO_TA_KEY1);
        wr(`SBO_OFS_TIMED_ACCESS, `SBO_TA_KEY2);
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    initial begin
        reset_n = 1'b0;
        clk_en = 1'b1;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h1;
        {pin, fault, wdt_req, low_vdd, debug_mode, debug_halt, prog_sel} = 7'h40;
        pwm_enable = 6'h00;
        prog_data = 8'h00;
        checked = 0;
        miscompares = 0;
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        wait_run();
        for (i = 0; i < 4; i++) begin
            rd_chk(5'(i * 4), `SBO_OPT_ERASED);
        end
        chk("boot_from_loader", 0, 32'(co.boot_from_loader));
        chk("app_kbytes", 32'h20, 32'(co.app_kbytes));
        chk("debug_enable", 0, 32'(co.debug_enable));
        chk("reset_pin_active", 1, 32'(co.reset_pin_active));
        chk("bod_enable", 1, 32'(co.bod_enable));
        chk("bod_level", 3, 32'(co.bod_level));
        chk("wdt_reset_en", 0, 32'(co.wdt_reset_en));
        // Loader boot, debug on, pwm tri-state on halt, reset pin kept
        wr(`SBO_OFS_BOOT_DEBUG_LOCK, 8'h26);
        wr(`SBO_OFS_BROWNOUT, 8'h00);
        rd_chk(`SBO_OFS_BROWNOUT, 8'h00);
        for (i = 0; i < 6; i++) begin
            wr(`SBO_OFS_LOADER_PART, ldr_v[i]);
            wr(`SBO_OFS_WATCHDOG, wdt_v[i]);
            pin_rst();
            chk("loader_kbytes", 32'(kb_v[i]), 32'(co.loader_kbytes));
            chk("app_kbytes", 32'(6'h20 - kb_v[i]), 32'(co.app_kbytes));
            chk("wdt_reset_en", 32'(wdt_v[i] != 8'hf0), 32'(co.wdt_reset_en));
            if (wdt_v[i] != 8'hf0) begin
                chk("wdt_run_in_idle", 32'(wdt_v[i] != 8'h50), 32'(co.wdt_run_in_idle));
            end
        end
        chk("boot_from_loader", 1, 32'(co.boot_from_loader));
        chk("debug_enable", 1, 32'(co.debug_enable));
        chk("bod_enable", 1, 32'(co.bod_enable));
        pwm_enable <= 6'h2d;
        debug_halt <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk("pwm_oe halted", 0, 32'(co.pwm_oe));
        debug_halt <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk("pwm_oe running", 32'h2d, 32'(co.pwm_oe));
        clk_en <= 1'b0;
        pwm_enable <= 6'h00;
        repeat (3) @(posedge clk_sys);
        chk("pwm_oe frozen", 32'h2d, 32'(co.pwm_oe));
        clk_en <= 1'b1;
        debug_mode <= 1'b1;
        fault <= 1'b1;
        @(posedge clk_sys);
        fault <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk("sys_reset on fault", 0, 32'(co.sys_reset));
        rd_chk(`SBO_OFS_AUX_RESET_FLAGS, 8'h60);
        wr(`SBO_OFS_AUX_RESET_FLAGS, 8'h40);
        rd_chk(`SBO_OFS_AUX_RESET_FLAGS, 8'h40);
        debug_mode <= 1'b0;
        // Window allowed to lapse before the trigger write
        unlock();
        repeat (8) @(posedge clk_sys);
        wr(`SBO_OFS_CHIP_CONTROL, 8'h80);
        repeat (3) @(posedge clk_sys);
        chk("sys_reset late trigger", 0, 32'(co.sys_reset));
        wr(`SBO_OFS_BOOT_DEBUG_LOCK, 8'ha6);
        unlock();
        wr(`SBO_OFS_CHIP_CONTROL, 8'h80);
        @(posedge clk_sys);
        chk("sys_reset soft", 1, 32'(co.sys_reset));
        chk("core_halt soft", 1, 32'(co.core_halt));
        rd_chk(`SBO_OFS_AUX_RESET_FLAGS, 8'hc0);
        wait_run();
        chk("boot_from_loader soft", 1, 32'(co.boot_from_loader));
        rd_chk(`SBO_OFS_AUX_RESET_FLAGS, 8'hc0);
        // Locked chip
        wr(`SBO_OFS_BOOT_DEBUG_LOCK, 8'h24);
        pin_rst();
        prog_data <= 8'h3c;
        repeat (3) @(posedge clk_sys);
        chk("prog_read_data locked", 32'hff, 32'(co.prog_read_data));
        chk("prog_write_ok locked", 0, 32'(co.prog_write_ok));
        prog_sel <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk("prog_read_data option", 32'h3c, 32'(co.prog_read_data));
        wr(`SBO_OFS_LOADER_PART, 8'h05);
        rd_chk(`SBO_OFS_LOADER_PART, 8'h00);
        unlock();
        wr(`SBO_OFS_CHIP_CONTROL, 8'h01);
        rd_chk(`SBO_OFS_BOOT_DEBUG_LOCK, 8'hff);
        rd_chk(`SBO_OFS_LOADER_PART, 8'hff);
        wr(`SBO_OFS_BOOT_DEBUG_LOCK, 8'hfb);
        pin_rst();
        pin <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk("sys_reset pin off", 0, 32'(co.sys_reset));
        chk("gpio_p20_in", 0, 32'(co.gpio_p20_in));
        chk("prog_write_ok erased", 1, 32'(co.prog_write_ok));
        // Brown-out options still erased from power-on
        low_vdd <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk("iap_allow low supply", 0, 32'(co.iap_allow));
        chk("sys_reset low supply", 1, 32'(co.sys_reset));
        print_verdict();
    end
endmodule
